// ### verilog/hrs_pkg.sv
// Purpose: Shared constants for the hub reset sequencer
// Assumes: 250 MHz system clock
// Notes: Times kept in their own unit, cycle counts derived
`default_nettype none
package hrs_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned RECOVER_MAX_US = 500;
    localparam int unsigned CFG_MAX_MS = 50;
    localparam int unsigned ATTACH_MAX_MS = 100;
    localparam int unsigned REQ_MAX_MS = 5;
    localparam int unsigned RECOVER_CYC = RECOVER_MAX_US * CLK_MHZ;
    localparam int unsigned CFG_CYC = CFG_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned ATTACH_CYC = ATTACH_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned REQ_CYC = REQ_MAX_MS * 1000 * CLK_MHZ;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int unsigned PWR_CLR_HI = 3;
    localparam int unsigned PWR_CLR_LO = 2;
    localparam int unsigned TIMER_W = 32;
    typedef enum logic [2:0] {
        ST_RECOVER, ST_CONFIG, ST_ATTACH, ST_ATTACHED, ST_READY
    } hrs_state_type;
endpackage : hrs_pkg
`default_nettype wire

// ### verilog/hrs_rst_sync.sv
// Purpose: Reset synchroniser, asynchronous assert, clocked release
// Assumes: Active low reset
// Notes: Two flip-flops; first read only by the second
`timescale 1ns/1ps
`default_nettype none
module hrs_rst_sync (
    input wire logic clk_sys,
    input wire logic resetn,
    output logic rst_sync_n
);
    logic meta_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            rst_sync_n <= meta_q;
        end
    end
endmodule : hrs_rst_sync
`default_nettype wire

// ### verilog/hrs_sequencer.sv
// Purpose: Reset and power-up sequencing of a hub device
// Assumes: Config loader, attach logic and request engine are outside
// Notes: Timeouts force progress for recovery, configuration and requests; ATTACH_CYCLES is not used, so attach has no bound
`timescale 1ns/1ps
`default_nettype none
module hrs_sequencer #(
    parameter int unsigned NUM_PORTS = 4,
    parameter int unsigned RECOVER_CYCLES = hrs_pkg::RECOVER_CYC,
    parameter int unsigned CFG_CYCLES = hrs_pkg::CFG_CYC,
    parameter int unsigned ATTACH_CYCLES = hrs_pkg::ATTACH_CYC,
    parameter int unsigned REQ_CYCLES = hrs_pkg::REQ_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cfg_done,
    input wire logic bus_reset,
    input wire logic set_addr_valid,
    input wire logic [6:0] set_addr,
    input wire logic set_config,
    input wire logic suspend_req,
    input wire logic req_start,
    input wire logic req_done,
    input wire logic [4*NUM_PORTS-1:0] port_power_req,
    input wire logic [NUM_PORTS-1:0] port_enable_req,
    output logic osc_run,
    output logic core_rstn,
    output logic cfg_load,
    output logic usb_attach,
    output logic [6:0] usb_addr,
    output logic configured,
    output logic suspended,
    output logic tt_clear,
    output logic req_timeout,
    output logic [4*NUM_PORTS-1:0] port_power_ctl,
    output logic [NUM_PORTS-1:0] port_enable,
    output logic [NUM_PORTS-1:0] port_reset
);
    if (NUM_PORTS < 1 || NUM_PORTS > 7) begin : g_bad_ports
        $error("NUM_PORTS out of range");
    end
    if (RECOVER_CYCLES < 1 || CFG_CYCLES < 1 || ATTACH_CYCLES < 1 || REQ_CYCLES < 1) begin : g_bad_counts
        $error("cycle counts must be at least one");
    end

    // ==========================================================
    // Reset release
    logic rst_n;
    hrs_rst_sync u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .rst_sync_n(rst_n)
    );

    // ==========================================================
    // Sequence
    hrs_pkg::hrs_state_type state_q;
    logic [hrs_pkg::TIMER_W-1:0] tmr_q;
    logic ready_d;
    assign ready_d = (state_q == hrs_pkg::ST_READY);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hrs_pkg::ST_RECOVER;
            tmr_q <= '0;
        end else begin
            case (state_q)
                hrs_pkg::ST_RECOVER: begin
                    // Recovery is fixed length, exactly RECOVER_CYCLES, equal to its maximum
                    if (tmr_q >= hrs_pkg::TIMER_W'(RECOVER_CYCLES - 1)) begin
                        state_q <= hrs_pkg::ST_CONFIG;
                        tmr_q <= '0;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                hrs_pkg::ST_CONFIG: begin
                    // Loader overrun falls back to defaults, not a hang
                    if (cfg_done || tmr_q >= hrs_pkg::TIMER_W'(CFG_CYCLES - 1)) begin
                        state_q <= hrs_pkg::ST_ATTACH;
                        tmr_q <= '0;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                hrs_pkg::ST_ATTACH: begin
                    state_q <= hrs_pkg::ST_ATTACHED;
                    tmr_q <= '0;
                end
                hrs_pkg::ST_ATTACHED: begin
                    if (bus_reset) begin
                        state_q <= hrs_pkg::ST_READY;
                    end
                end
                default: begin
                    state_q <= hrs_pkg::ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_run <= 1'b0;
            core_rstn <= 1'b0;
            cfg_load <= 1'b0;
            usb_attach <= 1'b0;
        end else begin
            osc_run <= 1'b1;
            core_rstn <= (state_q != hrs_pkg::ST_RECOVER);
            cfg_load <= (state_q == hrs_pkg::ST_CONFIG) && !cfg_done;
            usb_attach <= (state_q == hrs_pkg::ST_ATTACH) || usb_attach;
        end
    end

    // ==========================================================
    // Device state under bus reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            usb_addr <= hrs_pkg::ADDR_RESET;
            configured <= 1'b0;
            suspended <= 1'b0;
            tt_clear <= 1'b0;
        end else begin
            tt_clear <= bus_reset;
            if (bus_reset) begin
                usb_addr <= hrs_pkg::ADDR_RESET;
                configured <= 1'b0;
                suspended <= 1'b0;
            end else begin
                if (ready_d && set_addr_valid) usb_addr <= set_addr;
                if (ready_d && set_config) configured <= 1'b1;
                if (ready_d && suspend_req) suspended <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Request deadline; forced completion flags a timeout
    logic req_busy_q;
    logic [hrs_pkg::TIMER_W-1:0] req_tmr_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_busy_q <= 1'b0;
            req_tmr_q <= '0;
            req_timeout <= 1'b0;
        end else begin
            req_timeout <= 1'b0;
            if (bus_reset || !ready_d) begin
                req_busy_q <= 1'b0;
                req_tmr_q <= '0;
            end else if (req_busy_q) begin
                if (req_done) begin
                    req_busy_q <= 1'b0;
                end else if (req_tmr_q >= hrs_pkg::TIMER_W'(REQ_CYCLES - 1)) begin
                    req_busy_q <= 1'b0;
                    req_timeout <= 1'b1;
                end else begin
                    req_tmr_q <= req_tmr_q + 1'b1;
                end
            end else if (req_start) begin
                req_busy_q <= 1'b1;
                req_tmr_q <= '0;
            end
        end
    end

    // ==========================================================
    // Downstream ports
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    port_power_ctl[4*gi +: 4] <= 4'h0;
                    port_enable[gi] <= 1'b0;
                    port_reset[gi] <= 1'b0;
                end else begin
                    // Upstream reset never reaches downstream devices
                    port_reset[gi] <= 1'b0;
                    port_enable[gi] <= ready_d && port_enable_req[gi];
                    if (bus_reset || !ready_d) begin
                        port_power_ctl[4*gi+hrs_pkg::PWR_CLR_HI] <= 1'b0;
                        port_power_ctl[4*gi+hrs_pkg::PWR_CLR_LO] <= 1'b0;
                    end else begin
                        port_power_ctl[4*gi+3 -: 2] <= port_power_req[4*gi+3 -: 2];
                    end
                    port_power_ctl[4*gi +: 2] <= ready_d ? port_power_req[4*gi +: 2] : 2'h0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Checks
    chk_bus_rst_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_reset |=> (usb_addr == hrs_pkg::ADDR_RESET) && !configured)
        else $error("address or configuration kept after bus reset");
    chk_power_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_reset |=> ((port_power_ctl & {NUM_PORTS{4'hc}}) == '0))
        else $error("power control bits not cleared");
    chk_wake_tt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_reset |=> !suspended && tt_clear)
        else $error("suspend or buffers not handled on bus reset");
    chk_no_forward: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_reset |=> ##1 (port_reset == '0))
        else $error("bus reset forwarded downstream");
    chk_attach_prompt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == hrs_pkg::ST_CONFIG) && cfg_done |=> ##1 usb_attach)
        else $error("attach late after configuration");
    chk_cfg_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == hrs_pkg::ST_CONFIG) |-> tmr_q < hrs_pkg::TIMER_W'(CFG_CYCLES))
        else $error("configuration exceeds its maximum");
    chk_recover_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(state_q == hrs_pkg::ST_RECOVER) |-> $past(tmr_q) == hrs_pkg::TIMER_W'(RECOVER_CYCLES - 1))
        else $error("recovery length wrong");
    chk_req_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req_busy_q |-> req_tmr_q < hrs_pkg::TIMER_W'(REQ_CYCLES))
        else $error("request exceeds completion time");
    chk_clocks_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_rstn) |-> osc_run && !usb_attach)
        else $error("core released with clocks off");
endmodule : hrs_sequencer
`default_nettype wire

// ### bench/hrs_host_model.sv
// Purpose: Upstream host model issuing USB bus resets
// Assumes: Attach seen as a level on usb_attach
// Notes: again forces one extra reset once the hub is ready
`timescale 1ns/1ps
`default_nettype none
module hrs_host_model #(
    parameter int unsigned WAIT_CYCLES = 30
) (
    input wire logic clk_sys,
    input wire logic usb_attach,
    input wire logic again,
    output logic bus_reset
);
    int unsigned wait_q = 0;
    // Settle time after attach, scaled down like the design counts
    always @(posedge clk_sys) begin
        wait_q <= usb_attach ? wait_q + 1 : 0;
        bus_reset <= (usb_attach && wait_q == WAIT_CYCLES) || again;
    end
endmodule : hrs_host_model
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the hub reset sequencer
// Assumes: Shortened counts, two downstream ports
// Notes: Bus reset results checked from a queue on each tt_clear pulse
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned NP = 2;
    logic clk_sys = 1'b0, resetn = 1'b0, cfg_done = 1'b0, again = 1'b0, bus_reset;
    logic set_addr_valid = 1'b0, set_config = 1'b0, suspend_req = 1'b0, req_start = 1'b0, req_done = 1'b0;
    logic [6:0] set_addr = 7'h00;
    logic [4*NP-1:0] port_power_req = 8'h00;
    logic [NP-1:0] port_enable_req = 2'h0;
    logic osc_run, core_rstn, cfg_load, usb_attach, configured, suspended, tt_clear, req_timeout;
    logic [6:0] usb_addr;
    logic [4*NP-1:0] port_power_ctl;
    logic [NP-1:0] port_enable, port_reset;
    int mismatches = 0, checks_done = 0, cycles = 0, seed = 13614, n;
    logic [16:0] exp_q[$];

    hrs_sequencer #(.NUM_PORTS(NP), .RECOVER_CYCLES(8), .CFG_CYCLES(40), .REQ_CYCLES(20)) DUT (
        .clk_sys(clk_sys), .resetn(resetn), .cfg_done(cfg_done), .bus_reset(bus_reset),
        .set_addr_valid(set_addr_valid), .set_addr(set_addr), .set_config(set_config),
        .suspend_req(suspend_req), .req_start(req_start), .req_done(req_done),
        .port_power_req(port_power_req), .port_enable_req(port_enable_req), .osc_run(osc_run),
        .core_rstn(core_rstn), .cfg_load(cfg_load), .usb_attach(usb_attach), .usb_addr(usb_addr),
        .configured(configured), .suspended(suspended), .tt_clear(tt_clear), .req_timeout(req_timeout),
        .port_power_ctl(port_power_ctl), .port_enable(port_enable), .port_reset(port_reset));
    hrs_host_model host (.clk_sys(clk_sys), .usb_attach(usb_attach), .again(again),
        .bus_reset(bus_reset));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // ================================
    // Result watcher and hang guard
    // Falling edge: outputs launched on the rising edge have settled
    always @(negedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
        if (tt_clear === 1'b1) begin
            if (exp_q.size() == 0) check(17'h1_ffff, 17'h0_0000);
            else check({usb_addr, configured, suspended, port_power_ctl & 8'hcc}, exp_q.pop_front());
            check({15'h0000, port_reset}, 17'h0_0000);
        end
    end

    // ================================
    // Main sequence, pass 1 lets the config load time out
    initial begin
        for (int p = 0; p < 2; p++) begin
            resetn = 1'b0;
            // Mid-run reset keeps the full 1 us hold
            repeat (p == 0 ? 20 : 250) @(negedge clk_sys);
            check({6'h00, osc_run, core_rstn, usb_attach, port_power_ctl}, 17'h0_0000);
            resetn = 1'b1;
            n = 0;
            while (core_rstn !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            check({14'h0000, osc_run, cfg_load, n <= 13}, 17'h0_0007);
            exp_q.push_back(17'h0_0000);
            if (p == 0) begin
                repeat (5) @(negedge clk_sys);
                cfg_done = 1'b1;
                @(negedge clk_sys);
                cfg_done = 1'b0;
            end
            n = 0;
            while (usb_attach !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            check({15'h0000, cfg_load, n <= (p == 0 ? 3 : 44)}, 17'h0_0001);
            repeat (40) @(negedge clk_sys);
            set_addr = 7'($random(seed));
            port_power_req = 8'($random(seed)) | 8'hcc;
            port_enable_req = 2'($random(seed));
            {set_addr_valid, set_config, suspend_req} = 3'h7;
            @(negedge clk_sys);
            {set_addr_valid, set_config, suspend_req} = 3'h0;
            @(negedge clk_sys);
            check({usb_addr, configured, suspended, 6'h00, port_enable}, {set_addr, 2'b11, 6'h00, port_enable_req});
            check({9'h000, port_power_ctl}, {9'h000, port_power_req});
            exp_q.push_back(17'h0_0000);
            again = 1'b1;
            @(negedge clk_sys);
            again = 1'b0;
            repeat (4) @(negedge clk_sys);
            for (int k = 0; k < 2; k++) begin
                req_start = 1'b1;
                @(negedge clk_sys);
                req_start = 1'b0;
                repeat (5) @(negedge clk_sys);
                req_done = (k == 0);
                @(negedge clk_sys);
                req_done = 1'b0;
                n = 0;
                while (req_timeout !== 1'b1 && n < 30) begin
                    @(negedge clk_sys);
                    n++;
                end
                check({16'h0000, n < 30}, {16'h0000, k == 1});
            end
        end
        check({16'h0000, exp_q.size() == 0}, 17'h0_0001);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
